// ===== rtl/ptpc_defines.svh
/*
  timing and field constants for the periodic timer with pwm, single pulse and capture modes.
  assumes inclusion by bare name from rtl files; definitions only.
*/
`ifndef PTPC_DEFINES_SVH
`define PTPC_DEFINES_SVH
// ----------------------------------------
// mode and pin-function codes
// ----------------------------------------
`define PTPC_MODE_CAPTURE 2'h1
`define PTPC_MODE_PWM     2'h2
`define PTPC_PF_LOW       2'h0
`define PTPC_PF_HIGH      2'h1
`define PTPC_PF_PWM       2'h2
`define PTPC_PF_PULSE     2'h3
`define PTPC_CAP_RISE     2'h0
`define PTPC_CAP_FALL     2'h1
`define PTPC_CAP_BOTH     2'h2
`define PTPC_CAP_OFF      2'h3
// ----------------------------------------
// reset value and counter width
// ----------------------------------------
`define PTPC_CNT_RST      10'h000
`define PTPC_CNT_WIDTH    10
`endif

// ===== rtl/ptpc_pkg.sv
/*
  types shared by the periodic timer block.
  assumes ptpc_defines.svh is compiled alongside.
*/
package ptpc_pkg;
  // control bits from the two control registers
  typedef struct packed {
    logic [1:0] mode_sel;          // {mode_sel_hi, mode_sel_lo}
    logic [1:0] pin_func;          // {pin_func_hi, pin_func_lo}
    logic       clear_source_sel;
    logic       output_level_ctl;
    logic       output_invert;
    logic       capture_source_sel;
  } ptpc_ctrl_t;

  typedef enum logic [1:0] {PTPC_OTHER, PTPC_PWM, PTPC_PULSE, PTPC_CAPT} ptpc_op_t;
endpackage

// ===== rtl/ptpc_timer.sv
/*
  periodic 10-bit timer: pwm output, single pulse output and capture input.
  assumes pins synchronous to i_clk; tick input selects the counting clock rate.
*/
// Contract
// - mode 10 and pin function 10 give pwm
// - period match clears counter, duty sets width
// - period 1..1023 clocks, zero gives 1024
// - duty at or above period gives full duty
// - pwm flags duty match and period match
// - pin function 00/01 forces pin, counting continues
// - level bit picks active level, invert flips pin
// - pwm ignores clear select bit
// - run rise starts counter and pulse edge
// - trigger pin edge sets run bit
// - duty match or run clear ends pulse
// - pulse counter zeroes only on run rise
// - mode 01 capture, source select picks pin
// - pin function picks capture edge, 11 disables
// - capture copies counter into duty, flags interrupt
// - capture counter free runs while run high
// - capture period match zeroes counter, flags interrupt
// - capture ignores clear, level, invert; no output
// - level bit 0 active low, 1 high
// - invert bit 1 inverts pin
// - source select 0 timer pin, 1 clock pin
// - counter and compares are 10 bits
`timescale 1ns/1ns
`include "ptpc_defines.svh"

module ptpc_timer
  import ptpc_pkg::*;
#(
  parameter int CW = `PTPC_CNT_WIDTH
) (
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_tick,
  input  wire ptpc_ctrl_t    i_ctrl,
  input  wire logic          i_run_set,
  input  wire logic          i_run_clr,
  input  wire logic [CW-1:0] i_period_compare_value,
  input  wire logic          i_duty_wr,
  input  wire logic [CW-1:0] i_duty_wdata,
  input  wire logic          i_timer_pin_a,
  input  wire logic          i_ext_clock_trigger_pin,
  output logic               o_run_bit,
  output logic [CW-1:0]      o_count,
  output logic [CW-1:0]      o_duty_compare_value,
  output logic               o_duty_flag,
  output logic               o_period_flag,
  output logic               o_timer_pin_b,
  output logic               o_timer_pin_b_oe
);
  // ----------------------------------------
  // operating mode decode
  // ----------------------------------------
  wire logic      is_pwm_mode;
  wire logic      is_capt;
  wire ptpc_op_t  op;
  assign is_pwm_mode = (i_ctrl.mode_sel == `PTPC_MODE_PWM);
  assign is_capt     = (i_ctrl.mode_sel == `PTPC_MODE_CAPTURE);
  assign op = is_capt ? PTPC_CAPT :
              !is_pwm_mode ? PTPC_OTHER :
              (i_ctrl.pin_func == `PTPC_PF_PULSE) ? PTPC_PULSE : PTPC_PWM;

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] duty_q;
  logic          run_q;
  logic          run_d;
  logic          trig_prev_q;
  logic          cap_prev_q;
  logic          wave_q;
  logic          duty_flag_q;
  logic          period_flag_q;
  logic [CW-1:0] last_cnt;

  // ----------------------------------------
  // compares and edges
  // ----------------------------------------
  wire logic run_rise;
  wire logic period_hit;
  wire logic duty_hit;
  wire logic trig_edge;
  wire logic cap_src;
  wire logic cap_rise;
  wire logic cap_fall;
  wire logic cap_hit;
  wire logic full_duty;
  // zero period means wrap at max count, i.e. 1024 states
  assign last_cnt   = (i_period_compare_value == '0) ? '1 : i_period_compare_value - 1'b1;
  // start seen on the edge the run bit rises, so the count restarts together with the pulse
  assign run_rise   = run_d && !run_q;
  assign period_hit = run_q && i_tick && (cnt_q == last_cnt);
  assign duty_hit   = run_q && i_tick && (cnt_q + 1'b1 == duty_q);
  assign trig_edge  = i_ext_clock_trigger_pin && !trig_prev_q;
  assign cap_src    = i_ctrl.capture_source_sel ? i_ext_clock_trigger_pin : i_timer_pin_a;
  assign cap_rise   = cap_src && !cap_prev_q;
  assign cap_fall   = !cap_src && cap_prev_q;
  assign cap_hit    = is_capt && run_q &&
                      ((i_ctrl.pin_func == `PTPC_CAP_RISE && cap_rise) ||
                       (i_ctrl.pin_func == `PTPC_CAP_FALL && cap_fall) ||
                       (i_ctrl.pin_func == `PTPC_CAP_BOTH && (cap_rise || cap_fall)));
  // effective period is last_cnt+1; duty at or above gives steady active
  assign full_duty  = ({1'b0, duty_q} >= ({1'b0, last_cnt} + 11'h001));

  // ----------------------------------------
  // run bit: software, trigger pin, duty match
  // ----------------------------------------
  always_comb begin
    run_d = run_q;
    if (i_run_clr)
      run_d = 1'b0;
    if (i_run_set)
      run_d = 1'b1;
    if (op == PTPC_PULSE && trig_edge)
      run_d = 1'b1;
    if (op == PTPC_PULSE && duty_hit && run_q)
      run_d = 1'b0;
  end

  // ----------------------------------------
  // counter next value
  // ----------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    if (run_rise && op != PTPC_PWM)
      cnt_d = `PTPC_CNT_RST;
    else if (run_q && i_tick) begin
      if ((op == PTPC_PWM || op == PTPC_CAPT) && period_hit)
        cnt_d = `PTPC_CNT_RST;
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_q       <= `PTPC_CNT_RST;
      run_q       <= 1'b0;
      trig_prev_q <= 1'b0;
      cap_prev_q  <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      run_q       <= run_d;
      trig_prev_q <= i_ext_clock_trigger_pin;
      cap_prev_q  <= cap_src;
    end
  end

  // ----------------------------------------
  // duty register: software write or capture
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn)
      duty_q <= `PTPC_CNT_RST;
    else if (cap_hit)
      duty_q <= cnt_q;
    else if (i_duty_wr)
      duty_q <= i_duty_wdata;
  end

  // ----------------------------------------
  // interrupt flags, one-cycle pulses
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      duty_flag_q   <= 1'b0;
      period_flag_q <= 1'b0;
    end else begin
      // duty flag covers duty match and capture
      duty_flag_q   <= ((op == PTPC_PWM || op == PTPC_PULSE) && duty_hit) || cap_hit;
      period_flag_q <= (op == PTPC_PWM || op == PTPC_CAPT) && period_hit;
    end
  end

  // ----------------------------------------
  // active phase of the waveform
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn)
      wave_q <= 1'b0;
    else if (op == PTPC_PWM) begin
      if (full_duty)
        wave_q <= 1'b1;
      else
        wave_q <= (cnt_d < duty_q);
    end else if (op == PTPC_PULSE)
      wave_q <= run_d;
    else
      wave_q <= 1'b0;
  end

  // ----------------------------------------
  // output pin: force, level and invert
  // ----------------------------------------
  logic pin_d;
  always_comb begin
    pin_d = i_ctrl.output_level_ctl ? wave_q : !wave_q;
    if (op == PTPC_PWM && i_ctrl.pin_func == `PTPC_PF_LOW)
      pin_d = 1'b0;
    if (op == PTPC_PWM && i_ctrl.pin_func == `PTPC_PF_HIGH)
      pin_d = 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_timer_pin_b    <= 1'b0;
      o_timer_pin_b_oe <= 1'b0;
    end else begin
      o_timer_pin_b    <= pin_d ^ i_ctrl.output_invert;
      o_timer_pin_b_oe <= (op == PTPC_PWM || op == PTPC_PULSE);
    end
  end

  assign o_run_bit            = run_q;
  assign o_count              = cnt_q;
  assign o_duty_compare_value = duty_q;
  assign o_duty_flag          = duty_flag_q;
  assign o_period_flag        = period_flag_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PERIOD_WRAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PWM && period_hit && !run_rise) |=> cnt_q == '0)
    else $error("period match did not clear counter");
  AST_PULSE_END: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PULSE && duty_hit && !i_run_set && !trig_edge) |=> !run_q)
    else $error("duty match did not stop pulse");
  AST_TRIG_RUN: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PULSE && trig_edge) |=> run_q)
    else $error("trigger did not set run bit");
  AST_CAPTURE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cap_hit |=> (duty_q == $past(cnt_q)) && o_duty_flag)
    else $error("capture lost counter value");
  AST_CAP_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (is_capt && i_ctrl.pin_func == `PTPC_CAP_OFF) |-> !cap_hit)
    else $error("capture while disabled");
  AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!run_q && !run_rise) |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  AST_NO_OUT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    is_capt |=> !o_timer_pin_b_oe)
    else $error("output driven in capture");
  AST_PFLAG: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PWM && period_hit) |=> o_period_flag)
    else $error("period flag missing");

  // ----------------------------------------
  // pwm checks
  // ----------------------------------------
  // counting, waveform, forcing and flags while the pwm output runs
  // forced levels are checked with invert off only
  AST_PWM_COUNT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PWM && run_q && i_tick && !period_hit) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("pwm counter did not advance");
  AST_DUTY_FLAG_PWM: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PWM && duty_hit) |=> o_duty_flag)
    else $error("pwm duty flag missing");
  AST_FULL_DUTY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PWM && full_duty) |=> wave_q)
    else $error("full duty not steady active");
  AST_ZERO_DUTY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PWM && duty_q == '0) |=> !wave_q)
    else $error("zero duty gave active phase");
  AST_FORCE_LOW: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PWM && i_ctrl.pin_func == `PTPC_PF_LOW && !i_ctrl.output_invert) |=> !o_timer_pin_b)
    else $error("forced low pin not low");
  AST_FORCE_HIGH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PWM && i_ctrl.pin_func == `PTPC_PF_HIGH && !i_ctrl.output_invert) |=> o_timer_pin_b)
    else $error("forced high pin not high");
  AST_OE_ON: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PWM || op == PTPC_PULSE) |=> o_timer_pin_b_oe)
    else $error("output not enabled");

  // ----------------------------------------
  // single pulse checks
  // ----------------------------------------
  // start, free count, end on duty match and pin level
  // period compare never touches the pulse counter
  AST_PULSE_START: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PULSE && run_rise) |=> run_q && cnt_q == '0)
    else $error("pulse start did not zero counter");
  AST_PULSE_WAVE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PULSE && run_rise) |=> wave_q)
    else $error("pulse leading edge missing");
  AST_PULSE_COUNT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PULSE && run_q && i_tick) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("pulse counter cleared while running");
  AST_PULSE_NO_PFLAG: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PULSE) |=> !o_period_flag)
    else $error("period flag in pulse mode");
  AST_DFLAG_PULSE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PULSE && duty_hit) |=> o_duty_flag)
    else $error("pulse end flag missing");
  AST_PULSE_WAVE_END: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PULSE && duty_hit && !i_run_set && !trig_edge) |=> !wave_q)
    else $error("pulse trailing edge missing");
  AST_PULSE_PIN: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_PULSE && run_rise && i_ctrl.output_level_ctl && !i_ctrl.output_invert) ##1
    (op == PTPC_PULSE && i_ctrl.output_level_ctl && !i_ctrl.output_invert) |=> o_timer_pin_b)
    else $error("active high pulse not on pin");

  // ----------------------------------------
  // capture checks
  // ----------------------------------------
  // counter start, free run and wrap, duty register kept between events
  AST_CAPT_START: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_CAPT && run_rise) |=> cnt_q == '0 && run_q)
    else $error("capture start did not zero counter");
  AST_CAPT_FREE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_CAPT && run_q && i_tick && !period_hit) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("capture counter did not run");
  AST_CAPT_WRAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (op == PTPC_CAPT && period_hit) |=> cnt_q == '0 && o_period_flag)
    else $error("capture period match lost");
  AST_DUTY_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!cap_hit && !i_duty_wr) |=> $stable(duty_q))
    else $error("duty register changed without cause");
  AST_CAPT_NO_WAVE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    is_capt |=> !wave_q)
    else $error("waveform active in capture");

  // ----------------------------------------
  // run bit and duty write checks
  // ----------------------------------------
  // software set wins over clear; a duty match clear comes last
  AST_RUN_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_run_clr && !i_run_set && !(op == PTPC_PULSE && trig_edge)) |=> !run_q)
    else $error("run bit not cleared");
  AST_RUN_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_run_set && !(op == PTPC_PULSE && duty_hit)) |=> run_q)
    else $error("run bit not set");
  AST_DUTY_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_duty_wr && !cap_hit) |=> duty_q == $past(i_duty_wdata))
    else $error("duty write lost");
endmodule

// ===== bench/ptpc_pin_model.sv
/*
  far-side pin model: drives the capture and trigger pins of the timer.
  assumes toggle requests arrive as one-cycle pulses after a clock edge.
*/
`timescale 1ns/1ns
module ptpc_pin_model (
  input  wire logic i_clk,
  input  wire logic i_tgl_a,
  input  wire logic i_tgl_t,
  output logic      o_pin_a,
  output logic      o_pin_t
);
  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  initial begin
    o_pin_a = 1'b0;
    o_pin_t = 1'b0;
  end
  // pins are only driven toward the timer, never fed from its output
  always @(posedge i_clk) begin
    if (i_tgl_a) o_pin_a <= ~o_pin_a;
    if (i_tgl_t) o_pin_t <= ~o_pin_t;
  end
endmodule

// ===== bench/ptpc_timer_tb.sv
/*
  self-checking bench for the periodic timer: pwm, single pulse and capture.
  assumes ptpc_pkg, ptpc_timer and ptpc_pin_model are compiled first.
*/
`timescale 1ns/1ns
module ptpc_timer_tb;
  import ptpc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       clk = 1'b0, rstn = 1'b0, tick = 1'b1, rs = 1'b0, rc = 1'b0, dwr = 1'b0, ta = 1'b0, tt = 1'b0;
  logic       pa, pt, run, dflag, pflag, pin_b, oe;
  logic [9:0] per = 10'h000, dwd = 10'h000, cnt, dv, v[4];
  ptpc_ctrl_t ctrl = '0;
  int         num_errors = 0, compares = 0, cycles = 0, hi, df, pf, tdf, eff, n, last;
  ptpc_timer dut_u (.i_clk(clk), .i_rstn(rstn), .i_tick(tick), .i_ctrl(ctrl), .i_run_set(rs), .i_run_clr(rc),
    .i_period_compare_value(per), .i_duty_wr(dwr), .i_duty_wdata(dwd), .i_timer_pin_a(pa),
    .i_ext_clock_trigger_pin(pt), .o_run_bit(run), .o_count(cnt), .o_duty_compare_value(dv),
    .o_duty_flag(dflag), .o_period_flag(pflag), .o_timer_pin_b(pin_b), .o_timer_pin_b_oe(oe));
  ptpc_pin_model pins_u (.i_clk(clk), .i_tgl_a(ta), .i_tgl_t(tt), .o_pin_a(pa), .o_pin_t(pt));
  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_cnt(input int got, input int exp);
    compares++;
    if (got != exp) begin
      num_errors++;
      $display("Error %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic chk_v(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // counts pin-high cycles and flag pulses over a window
  task automatic win(input int k);
    hi = 0;
    df = 0;
    pf = 0;
    repeat (k) begin
      cyc(1);
      hi += int'(pin_b === 1'b1);
      df += int'(dflag === 1'b1);
      pf += int'(pflag === 1'b1);
    end
  endtask
  task automatic start(input logic [9:0] p, input logic [9:0] d);
    rstn = 1'b0;
    cyc(6);
    rstn = 1'b1;
    per = p;
    dwd = d;
    cyc(1);
    dwr = 1'b1;
    cyc(1);
    dwr = 1'b0;
  endtask
  task automatic go();
    rs = 1'b1;
    cyc(1);
    rs = 1'b0;
  endtask
  task automatic tgl(input bit on_a);
    ta = on_a;
    tt = !on_a;
    cyc(1);
    ta = 1'b0;
    tt = 1'b0;
  endtask
  // expected pin-high cycles over n whole periods
  function automatic int exp_hi(int e, int d, int k, ptpc_ctrl_t c);
    int w = (d > e ? e : d) * k;
    if (c.pin_func != 2'h2) return c.pin_func[0] ? e * k : 0;
    if (!c.output_level_ctl) w = e * k - w;
    return c.output_invert ? e * k - w : w;
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    hi = $urandom(32'hC1429C9E);
    for (int k = 0; k < 9; k++) begin
      ctrl = '{2'h2, (k == 6 || k == 7) ? 2'(k - 6) : 2'h2, 1'($urandom), 1'($urandom),
               (k == 6 || k == 7) ? 1'b0 : 1'($urandom), 1'b0};
      eff = (k == 8) ? 1024 : 2 + $urandom % 40;
      n = (k == 8) ? 1 : 4;
      start(10'(eff), (k == 8) ? 10'h12C : (k == 5) ? 10'(eff) : 10'(1 + $urandom % (eff + 3)));
      go();
      cyc(eff + 4);
      win(eff * n);
      chk_cnt(hi, exp_hi(eff, int'(dwd), n, ctrl));
      chk_cnt(pf, n);
      chk_cnt(df, int'(dwd) <= eff ? n : 0);
      if (ctrl.pin_func == 2'h2) chk_v(10'(oe), 10'h001);
    end
    v[0] = cnt;
    tick = 1'b0;
    cyc(5);
    chk_v(cnt, v[0]);
    tick = 1'b1;
    ctrl = '{2'h2, 2'h3, 1'($urandom), 1'b1, 1'b0, 1'b0};
    start(10'h003, 10'h007);
    go();
    win(40);
    chk_cnt(hi, 7);
    chk_cnt(df, 1);
    chk_v(10'(run), 10'h000);
    tgl(1'b0);
    win(40);
    chk_cnt(hi, 7);
    go();
    cyc(2);
    rc = 1'b1;
    win(40);
    rc = 1'b0;
    chk_cnt(int'(hi < 5), 1);
    tgl(1'b0);
    for (int k = 0; k < 8; k++) begin
      ctrl = '{2'h1, 2'(k), 1'($urandom), 1'($urandom), 1'($urandom), 1'(k / 4)};
      start(10'h000, 10'h155);
      go();
      tgl(k >= 4);
      cyc(1);
      tgl(k >= 4);
      win(6);
      tdf = df;
      last = -1;
      for (int e = 0; e < 4; e++) begin
        tgl(k < 4);
        win(12);
        tdf += df;
        v[e] = dv;
        if (k % 4 == 2 || (k % 4 == 0 && e % 2 == 0) || (k % 4 == 1 && e % 2 == 1)) begin
          if (last >= 0) chk_v(v[e] - v[last], 10'(13 * (e - last)));
          last = e;
        end else chk_v(v[e], e ? v[e - 1] : 10'h155);
      end
      chk_cnt(tdf, (k % 4 == 3) ? 0 : (k % 4 == 2) ? 4 : 2);
      chk_v(10'(oe), 10'h000);
    end
    ctrl = '{2'h1, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0};
    start(10'h014, 10'h000);
    go();
    cyc(25);
    win(100);
    chk_cnt(pf, 5);
    chk_cnt(int'(cnt < 10'h014), 1);
    wrap_up();
  end
endmodule
